/* File: rtl/pdp_port.sv */
// Power-driver ports with H-bridge PWM control, short flags and a generic GPIO port
//
// Behaviour
// - Port F short-flag register: bits 3..0 flag faults, bits 7..4 read zero.
// - Writing one clears a short flag; writing zero leaves it.
// - Forward state: switches 1,2 off; switches 0,3 on.
// - Backward state: switches 0,3 off; switches 1,2 on.
// - Off state: switches 0,2 off; switches 1,3 on.
// - Static line holds its side high; PWM line pulls opposite side low.
// - PWM alternates forward/off or backward/off; ratio sets average current.
// - Direction reversal moves forward/backward and swaps line roles.
// - Current is linear in nine-bit two's-complement channel value.
// - Direction bit change swaps PWM/static roles but leaves PWM polarity unchanged.
// - Negative channel values invert the generated PWM.
// - Build option forces power ports low in wait mode, or not.
// - GPIO pin is output when direction bit is one, else input.
// - Reset clears every direction bit: pins start as inputs.
// - Direction register is readable and writable.
// - Data write with direction zero updates latch only.
// - Data write with direction one updates latch and drives pin.
// - Data read returns pin for inputs, latch for outputs.
// - Read-modify-write on input pin reads pin, stores result in latch.
// - Output level compared with command, sampled just after PWM period start.
// - Per-bit select chooses data register or PWM for each output.
// - Port E eight-bit short-flag register, each bit cleared by writing one.
`timescale 1ns/100ps
module pdp_port #(
    parameter bit WAIT_FORCE_LOW = 1'b1,
    parameter int GPIO_WIDTH = 8
) (
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic clk_en_in,
    input wire logic wait_mode_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [7:0] port_e_pin_in,
    input wire logic [3:0] port_f_pin_in,
    output logic [7:0] port_e_out,
    output logic [3:0] port_f_out,
    input wire logic [GPIO_WIDTH-1:0] gpio_pin_in,
    output logic [GPIO_WIDTH-1:0] gpio_out,
    output logic [GPIO_WIDTH-1:0] gpio_oe_out
);
    // GPIO data and direction registers are one byte wide, so wider ports cannot be served
    if (GPIO_WIDTH < 1 || GPIO_WIDTH > 8) begin : g_bad_gpio_width
        $error("GPIO_WIDTH must be 1..8");
    end

    logic [7:0] port_e_data;
    logic [3:0] port_f_data;
    logic [7:0] port_e_short_flags;
    logic [3:0] port_f_short_flags;
    logic [11:0] pwm_output_select;
    logic [1:0] bridge_sign;
    logic [8:0] ch_value [2];
    logic [GPIO_WIDTH-1:0] gpio_latch;
    logic [GPIO_WIDTH-1:0] gpio_dir;
    logic [7:0] pwm_cnt;
    logic [7:0] sample_cnt;
    logic [3:0] pwm_raw;
    logic [7:0] e_cmd;
    logic [3:0] f_cmd;
    logic sample_now;
    logic [31:0] next_rdata;
    logic wr_acc;
    logic [7:0] wbyte;
    logic [GPIO_WIDTH-1:0] gpio_read;
    pdp_pkg::pdp_bridge_t bstate [2];

    assign wr_acc = psel_in && penable_in && pwrite_in && clk_en_in;
    assign wbyte = pwdata_in[7:0];
    assign pready_out = 1'b1;
    assign pslverr_out = 1'b0;

    // Shared period counter for the two PWM generators (channels 0 and 2)
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            pwm_cnt <= 8'h00;
        end else if (clk_en_in) begin
            pwm_cnt <= pwm_cnt + 8'h01;
        end
    end

    // Sample one clock after the period starts so the driver output has settled
    assign sample_now = clk_en_in && (pwm_cnt == 8'(pdp_pkg::SAMPLE_DELAY_CYC));
    assign sample_cnt = pwm_cnt;

    // One generator per bridge; all share the period counter
    for (genvar b = 0; b < 2; b++) begin : g_chan
        pdp_pwm_chan u_chan (
            .cnt_in(sample_cnt),
            .value_in(ch_value[b]),
            .pwm_out(pwm_raw[2*b])
        );
        // Odd channels have no generator here and idle low
        assign pwm_raw[2*b+1] = 1'b0;
    end

    // Bridge state per channel pair: forward/off or backward/off only
    always_comb begin
        for (int b = 0; b < 2; b++) begin
            if (!pwm_raw[2*b]) begin
                bstate[b] = pdp_pkg::PDP_ST_OFF;
            end else if (bridge_sign[b]) begin
                bstate[b] = pdp_pkg::PDP_ST_BWD;
            end else begin
                bstate[b] = pdp_pkg::PDP_ST_FWD;
            end
        end
    end

    // Map states to {sw3,sw2,sw1,sw0}; sw0/sw1 form left line, sw2/sw3 right line
    function automatic logic [3:0] pdp_switches(input pdp_pkg::pdp_bridge_t st);
        logic [3:0] sw;
        sw = pdp_pkg::BRIDGE_OFF;
        case (st)
            pdp_pkg::PDP_ST_FWD: sw = pdp_pkg::BRIDGE_FWD;
            pdp_pkg::PDP_ST_BWD: sw = pdp_pkg::BRIDGE_BWD;
            pdp_pkg::PDP_ST_OFF: sw = pdp_pkg::BRIDGE_OFF;
            default: sw = pdp_pkg::BRIDGE_OFF;
        endcase
        return sw;
    endfunction

    // Each line of a bridge nibble drives one switch; static side stays on
    always_comb begin
        logic [3:0] sw_pat;
        sw_pat = 4'h0;
        e_cmd = 8'h00;
        for (int b = 0; b < 2; b++) begin
            sw_pat = pdp_switches(bstate[b]);
            // Sign swaps which side toggles, so roles trade places
            e_cmd[4*b +: 4] = sw_pat;
        end
        for (int i = 0; i < 8; i++) begin
            if (!pwm_output_select[i]) begin
                e_cmd[i] = port_e_data[i];
            end
        end
        for (int i = 0; i < 4; i++) begin
            f_cmd[i] = pwm_output_select[8+i] ? pwm_raw[i] : port_f_data[i];
        end
    end

    // Wait-mode policy is fixed at build time
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            port_e_out <= 8'h00;
        end else if (clk_en_in) begin
            if (WAIT_FORCE_LOW && wait_mode_in) begin
                port_e_out <= 8'h00;
            end else begin
                port_e_out <= e_cmd;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            port_f_out <= 4'h0;
        end else if (clk_en_in) begin
            if (WAIT_FORCE_LOW && wait_mode_in) begin
                port_f_out <= 4'h0;
            end else begin
                port_f_out <= f_cmd;
            end
        end
    end

    // Registered outputs are compared, so a flag means the pin disagrees
    pdp_flag_bank #(
        .WIDTH(8)
    ) u_flags_e (
        .core_clk_in(core_clk_in),
        .srst_in(srst_in),
        .clk_en_in(clk_en_in),
        .sample_in(sample_now),
        .cmd_in(port_e_out),
        .pin_in(port_e_pin_in),
        .clr_stb_in(wr_acc && paddr_in == pdp_pkg::ADDR_PORTE_SHORT),
        .clr_mask_in(wbyte),
        .flags_out(port_e_short_flags)
    );

    pdp_flag_bank #(
        .WIDTH(4)
    ) u_flags_f (
        .core_clk_in(core_clk_in),
        .srst_in(srst_in),
        .clk_en_in(clk_en_in),
        .sample_in(sample_now),
        .cmd_in(port_f_out),
        .pin_in(port_f_pin_in),
        .clr_stb_in(wr_acc && paddr_in == pdp_pkg::ADDR_PORTF_SHORT),
        .clr_mask_in(wbyte[3:0]),
        .flags_out(port_f_short_flags)
    );

    // Port data registers
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            port_e_data <= pdp_pkg::RST_DATA;
            port_f_data <= pdp_pkg::RST_DATA[3:0];
        end else if (wr_acc) begin
            if (paddr_in == pdp_pkg::ADDR_PORTE_DATA) begin
                port_e_data <= wbyte;
            end
            if (paddr_in == pdp_pkg::ADDR_PORTF_DATA) begin
                port_f_data <= wbyte[3:0];
            end
        end
    end

    // PWM routing, bridge direction and channel values
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            pwm_output_select <= 12'h000;
            bridge_sign <= 2'b00;
            ch_value[0] <= 9'h000;
            ch_value[1] <= 9'h000;
        end else if (wr_acc) begin
            case (paddr_in)
                pdp_pkg::ADDR_PWM_SELECT: begin
                    pwm_output_select <= pwdata_in[11:0];
                end
                pdp_pkg::ADDR_PWM_CTRL: begin
                    bridge_sign[0] <= pwdata_in[pdp_pkg::PWM_CTRL_SIGN0_POS];
                    bridge_sign[1] <= pwdata_in[pdp_pkg::PWM_CTRL_SIGN1_POS];
                end
                pdp_pkg::ADDR_CH_VALUE0: begin
                    ch_value[0] <= pwdata_in[8:0];
                end
                pdp_pkg::ADDR_CH_VALUE1: begin
                    ch_value[1] <= pwdata_in[8:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Latch is always written; the direction only decides whether it reaches the pin
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            gpio_latch <= pdp_pkg::RST_DATA[GPIO_WIDTH-1:0];
        end else if (wr_acc && paddr_in == pdp_pkg::ADDR_GPIO_DATA) begin
            // No bus RMW: software reads the pin and writes the result here
            gpio_latch <= pwdata_in[GPIO_WIDTH-1:0];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            gpio_dir <= pdp_pkg::RST_DIR[GPIO_WIDTH-1:0];
        end else if (wr_acc && paddr_in == pdp_pkg::ADDR_GPIO_DIR) begin
            gpio_dir <= pwdata_in[GPIO_WIDTH-1:0];
        end
    end

    assign gpio_out = gpio_latch;
    assign gpio_oe_out = gpio_dir;
    assign gpio_read = (gpio_dir & gpio_latch) | (~gpio_dir & gpio_pin_in);

    // Read mux; unmapped addresses read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (paddr_in)
            pdp_pkg::ADDR_PORTE_DATA: begin
                next_rdata = {24'h000000, port_e_data};
            end
            pdp_pkg::ADDR_PORTF_DATA: begin
                next_rdata = {28'h0000000, port_f_data};
            end
            pdp_pkg::ADDR_PORTE_SHORT: begin
                next_rdata = {24'h000000, port_e_short_flags};
            end
            pdp_pkg::ADDR_PORTF_SHORT: begin
                next_rdata = {28'h0000000, port_f_short_flags};
            end
            pdp_pkg::ADDR_PWM_SELECT: begin
                next_rdata = {20'h00000, pwm_output_select};
            end
            pdp_pkg::ADDR_PWM_CTRL: begin
                next_rdata = {30'h00000000, bridge_sign};
            end
            pdp_pkg::ADDR_CH_VALUE0: begin
                next_rdata = {23'h000000, ch_value[0]};
            end
            pdp_pkg::ADDR_CH_VALUE1: begin
                next_rdata = {23'h000000, ch_value[1]};
            end
            pdp_pkg::ADDR_GPIO_DATA: begin
                next_rdata = 32'(gpio_read);
            end
            pdp_pkg::ADDR_GPIO_DIR: begin
                next_rdata = 32'(gpio_dir);
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    // Data registered during setup so it is stable in the access phase
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (clk_en_in && psel_in && !penable_in) begin
            prdata_out <= next_rdata;
        end
    end
endmodule

// One PWM generator: duty from the low eight bits of a nine-bit value
module pdp_pwm_chan (
    input wire logic [7:0] cnt_in,
    input wire logic [8:0] value_in,
    output logic pwm_out
);
    logic below;

    // Unsigned compare: a positive value gives value/256 high time
    assign below = cnt_in < value_in[7:0];
    // Negative values invert, so the high time is the magnitude over 256
    assign pwm_out = value_in[pdp_pkg::CH_SIGN_POS] ? ~below : below;
endmodule

// Short-flag bank: mismatch latched at the sample strobe, cleared by writing one
module pdp_flag_bank #(
    parameter int WIDTH = 8
) (
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic clk_en_in,
    input wire logic sample_in,
    input wire logic [WIDTH-1:0] cmd_in,
    input wire logic [WIDTH-1:0] pin_in,
    input wire logic clr_stb_in,
    input wire logic [WIDTH-1:0] clr_mask_in,
    output logic [WIDTH-1:0] flags_out
);
    logic [WIDTH-1:0] set_mask;

    if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
        $error("WIDTH must be 1..8");
    end

    // A shorted line reads back at the other rail
    assign set_mask = sample_in ? (cmd_in ^ pin_in) : '0;

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            flags_out <= pdp_pkg::RST_FLAGS[WIDTH-1:0];
        end else if (clk_en_in) begin
            if (clr_stb_in) begin
                // Set wins, so a fault in the clearing cycle is never lost
                flags_out <= (flags_out & ~clr_mask_in) | set_mask;
            end else begin
                flags_out <= flags_out | set_mask;
            end
        end
    end
endmodule

/* File: rtl/pdp_pkg.sv */
// Register map, field layout and reset values of the power-driver port block
package pdp_pkg;
    // Register indices; each register is one aligned word, byte address is four times these
    localparam logic [9:0] IDX_PORTE_DATA = 10'h040;
    localparam logic [9:0] IDX_PORTF_DATA = 10'h042;
    localparam logic [9:0] IDX_PORTE_SHORT = 10'h044;
    localparam logic [9:0] IDX_PORTF_SHORT = 10'h043;
    localparam logic [9:0] IDX_PWM_SELECT = 10'h048;
    localparam logic [9:0] IDX_PWM_CTRL = 10'h04C;
    localparam logic [9:0] IDX_CH_VALUE0 = 10'h050;
    localparam logic [9:0] IDX_CH_VALUE1 = 10'h054;
    localparam logic [9:0] IDX_GPIO_DATA = 10'h060;
    localparam logic [9:0] IDX_GPIO_DIR = 10'h064;
    // Byte addresses of the registers on APB
    localparam logic [11:0] ADDR_PORTE_DATA = {IDX_PORTE_DATA, 2'b00};
    localparam logic [11:0] ADDR_PORTF_DATA = {IDX_PORTF_DATA, 2'b00};
    localparam logic [11:0] ADDR_PORTE_SHORT = {IDX_PORTE_SHORT, 2'b00};
    localparam logic [11:0] ADDR_PORTF_SHORT = {IDX_PORTF_SHORT, 2'b00};
    localparam logic [11:0] ADDR_PWM_SELECT = {IDX_PWM_SELECT, 2'b00};
    localparam logic [11:0] ADDR_PWM_CTRL = {IDX_PWM_CTRL, 2'b00};
    localparam logic [11:0] ADDR_CH_VALUE0 = {IDX_CH_VALUE0, 2'b00};
    localparam logic [11:0] ADDR_CH_VALUE1 = {IDX_CH_VALUE1, 2'b00};
    localparam logic [11:0] ADDR_GPIO_DATA = {IDX_GPIO_DATA, 2'b00};
    localparam logic [11:0] ADDR_GPIO_DIR = {IDX_GPIO_DIR, 2'b00};
    // Reset values
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [7:0] RST_DIR = 8'h00;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    // Field positions
    localparam int PWM_CTRL_SIGN0_POS = 0;
    localparam int PWM_CTRL_SIGN1_POS = 1;
    localparam int CH_SIGN_POS = 8;
    // Short-flag sample point: quarter of a bus cycle after period start, one clock here
    localparam int SAMPLE_DELAY_CYC = 1;
    localparam int PWM_PERIOD_CYC = 256;
    // Bridge switch patterns {sw3,sw2,sw1,sw0}
    localparam logic [3:0] BRIDGE_FWD = 4'h9;
    localparam logic [3:0] BRIDGE_BWD = 4'h6;
    localparam logic [3:0] BRIDGE_OFF = 4'hA;
    typedef enum logic [2:0] {
        PDP_ST_OFF = 3'h1,
        PDP_ST_FWD = 3'h2,
        PDP_ST_BWD = 3'h4
    } pdp_bridge_t;
endpackage

/* File: test/pdp_driver_model.sv */
// Power driver stage model
`timescale 1ns/100ps
module pdp_driver_model (
    input wire logic [7:0] cmd_e_in,
    input wire logic [3:0] cmd_f_in,
    input wire logic [7:0] short_e_in,
    input wire logic [3:0] short_f_in,
    output logic [7:0] pin_e_out,
    output logic [3:0] pin_f_out
);
    // Shorted line reads back at the opposite rail
    assign pin_e_out = cmd_e_in ^ short_e_in;
    assign pin_f_out = cmd_f_in ^ short_f_in;
endmodule

/* File: test/pdp_port_props.sv */
// Pin-level assertions for the power-driver port block
`timescale 1ns/100ps
module pdp_port_props #(
    parameter bit WAIT_FORCE_LOW = 1'b1,
    parameter int GPIO_WIDTH = 8
) (
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic clk_en_in,
    input wire logic wait_mode_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic [7:0] port_e_out,
    input wire logic [3:0] port_f_out,
    input wire logic [GPIO_WIDTH-1:0] gpio_pin_in,
    input wire logic [GPIO_WIDTH-1:0] gpio_out,
    input wire logic [GPIO_WIDTH-1:0] gpio_oe_out
);
    wire logic wr = psel_in && penable_in && pwrite_in && clk_en_in;
    wire logic dir_wr = wr && paddr_in == pdp_pkg::ADDR_GPIO_DIR;
    wire logic dat_wr = wr && paddr_in == pdp_pkg::ADDR_GPIO_DATA;
    // Latch where driving, pin elsewhere
    wire logic [GPIO_WIDTH-1:0] mux = (gpio_oe_out & gpio_out) | (~gpio_oe_out & gpio_pin_in);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (srst_in);
    sequence s_setup(logic [11:0] a);
        psel_in && !penable_in && !pwrite_in && clk_en_in && paddr_in == a;
    endsequence
    sequence s_access;
        psel_in && penable_in;
    endsequence
    a_dir_reset_clear: assert property ($fell(srst_in) |-> gpio_oe_out == '0)
        else $error("dir not cleared");
    a_dir_write: assert property (dir_wr |=>
        gpio_oe_out == $past(pwdata_in[GPIO_WIDTH-1:0])) else $error("dir write lost");
    a_dir_hold: assert property (!dir_wr |=> $stable(gpio_oe_out))
        else $error("dir changed");
    a_latch_write: assert property (dat_wr |=>
        gpio_out == $past(pwdata_in[GPIO_WIDTH-1:0])) else $error("latch write lost");
    a_latch_hold: assert property (!dat_wr |=> $stable(gpio_out))
        else $error("latch changed");
    a_read_mux: assert property (s_setup(pdp_pkg::ADDR_GPIO_DATA) ##1 s_access |->
        prdata_out[GPIO_WIDTH-1:0] == $past(mux)) else $error("data read wrong");
    a_flagf_upper: assert property (s_setup(pdp_pkg::ADDR_PORTF_SHORT) ##1 s_access |->
        prdata_out[31:4] == 28'h0) else $error("flag upper bits set");
    a_wait_low: assert property ((WAIT_FORCE_LOW && wait_mode_in) [*2] |->
        port_e_out == 8'h00 && port_f_out == 4'h0) else $error("ports not low");
endmodule
bind pdp_port pdp_port_props #(.WAIT_FORCE_LOW(WAIT_FORCE_LOW), .GPIO_WIDTH(GPIO_WIDTH))
    u_props (.core_clk_in, .srst_in, .clk_en_in, .wait_mode_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .port_e_out, .port_f_out, .gpio_pin_in,
    .gpio_out, .gpio_oe_out);

/* File: test/pdp_port_tb.sv */
// Self-checking bench for the power-driver port block
`timescale 1ns/100ps
module pdp_port_tb;
    logic core_clk_in = 1'b0, srst_in = 1'b1, wait_mode_in = 1'b0, pready_out, clk_en_in = 1'b1;
    logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rdata;
    logic [7:0] gpio_pin_in = 8'h00, short_e = 8'h00, port_e_out, pin_e, gpio_out, gpio_oe_out;
    logic [3:0] short_f = 4'h0, port_f_out, pin_f;
    int num_errors = 0, check_count = 0;
    always #20 core_clk_in = ~core_clk_in;
    pdp_port u_dut (.core_clk_in, .srst_in, .clk_en_in, .wait_mode_in, .psel_in,
        .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
        .pslverr_out(), .port_e_pin_in(pin_e), .port_f_pin_in(pin_f), .port_e_out,
        .port_f_out, .gpio_pin_in, .gpio_out, .gpio_oe_out);
    pdp_driver_model u_drv (.cmd_e_in(port_e_out), .cmd_f_in(port_f_out),
        .short_e_in(short_e), .short_f_in(short_f), .pin_e_out(pin_e), .pin_f_out(pin_f));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask
    // Ready is waited for, never assumed
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n = 0;
        @(posedge core_clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge core_clk_in);
        penable_in <= 1'b1;
        do @(posedge core_clk_in); while (pready_out !== 1'b1 && ++n < 64);
        if (pready_out !== 1'b1) num_errors++;
        rdata = prdata_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        chk(rdata, exp);
    endtask
    task automatic t_gpio;
        rd(pdp_pkg::ADDR_GPIO_DIR, 32'h0);
        apb(pdp_pkg::ADDR_GPIO_DIR, 1'b1, 32'h0F);
        rd(pdp_pkg::ADDR_GPIO_DIR, 32'h0F);
        apb(pdp_pkg::ADDR_GPIO_DATA, 1'b1, 32'hA5);
        cyc(1);
        chk(gpio_out, 32'hA5);
        chk(gpio_oe_out, 32'h0F);
        gpio_pin_in <= 8'h3C;
        rd(pdp_pkg::ADDR_GPIO_DATA, 32'h35);
        apb(pdp_pkg::ADDR_GPIO_DATA, 1'b1, rdata ^ 32'hFF);
        cyc(1);
        chk(gpio_out, 32'hCA);
        rd(12'h07C, 32'h0);
    endtask
    // Writes while the clock enable is low must be lost
    task automatic t_clken;
        clk_en_in <= 1'b0;
        apb(pdp_pkg::ADDR_GPIO_DATA, 1'b1, 32'h11);
        clk_en_in <= 1'b1;
        cyc(1);
        chk(gpio_out, 32'hCA);
    endtask
    task automatic t_flags;
        rd(pdp_pkg::ADDR_PORTF_SHORT, 32'h0);
        apb(pdp_pkg::ADDR_PORTF_DATA, 1'b1, 32'hF);
        short_f <= 4'h2;
        short_e <= 8'h80;
        cyc(300);
        short_f <= 4'h0;
        short_e <= 8'h00;
        rd(pdp_pkg::ADDR_PORTF_SHORT, 32'h2);
        rd(pdp_pkg::ADDR_PORTE_SHORT, 32'h80);
        apb(pdp_pkg::ADDR_PORTF_SHORT, 1'b1, 32'h0);
        rd(pdp_pkg::ADDR_PORTF_SHORT, 32'h2);
        apb(pdp_pkg::ADDR_PORTF_SHORT, 1'b1, 32'hFF);
        rd(pdp_pkg::ADDR_PORTF_SHORT, 32'h0);
    endtask
    task automatic t_wait;
        wait_mode_in <= 1'b1;
        cyc(3);
        chk(port_f_out, 32'h0);
        wait_mode_in <= 1'b0;
        cyc(3);
        chk(port_f_out, 32'hF);
    endtask
    task automatic t_bridge(input logic s, input logic [8:0] v, input logic [3:0] on);
        int hits = 0;
        apb(pdp_pkg::ADDR_PWM_SELECT, 1'b1, 32'hFF);
        apb(pdp_pkg::ADDR_PWM_CTRL, 1'b1, {30'h0, s, s});
        apb(pdp_pkg::ADDR_CH_VALUE0, 1'b1, {23'h0, v});
        apb(pdp_pkg::ADDR_CH_VALUE1, 1'b1, {23'h0, v});
        cyc(260);
        repeat (256) begin
            cyc(1);
            for (int b = 0; b < 8; b += 4) begin
                if (port_e_out[b +: 4] === on) hits++;
                else chk(port_e_out[b +: 4], pdp_pkg::BRIDGE_OFF);
            end
        end
        chk(hits, 32'd128);
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge core_clk_in);
        srst_in <= 1'b0;
        t_gpio;
        t_clken;
        t_flags;
        t_wait;
        t_bridge(1'b0, 9'h040, pdp_pkg::BRIDGE_FWD);
        t_bridge(1'b1, 9'h1C0, pdp_pkg::BRIDGE_BWD);
        end_of_test;
    end
    initial begin
        #(40 * 4000);
        num_errors++;
        end_of_test;
    end
endmodule
